// [logic/refsel_defs.vh]
`ifndef REFSEL_DEFS_VH
`define REFSEL_DEFS_VH

// Register addresses on the special-function register bus.
`define ADDR_TEMP_OFFSET_LOW 8'h85
`define ADDR_TEMP_OFFSET_HIGH 8'h86
`define ADDR_REFERENCE_CONTROL 8'hd1

// Field positions of the reference control register.
`define POS_GND_SEL 5
`define POS_VREF_SEL_HI 4
`define POS_VREF_SEL_LO 3
`define POS_SENSOR_ON 2
`define POS_PREC_OE 0

// Field positions of the offset low register.
`define POS_OFFSET_LOW_HI 7
`define POS_OFFSET_LOW_LO 6

// Reset value of the reference control register.
`define RESET_REFERENCE_CONTROL 8'h18

// Writable bit mask of the reference control register.
`define MASK_REFERENCE_CONTROL 8'h3d

// Reference select codes.
`define VREF_EXT_PIN 2'h0
`define VREF_MAIN_SUPPLY 2'h1
`define VREF_DIGITAL_SUPPLY 2'h2
`define VREF_HIGH_SPEED 2'h3

// Ground select codes driven to the ground multiplexer.
`define GND_CHIP 1'b0
`define GND_ANALOG_PIN 1'b1

`endif

// [logic/adc_reference_select_control.v]
// How it works
// RQ1: Offset low register shows offset bits 1:0 in its bits 7:6, read only.
// RQ2: Offset low bits 5:0 read zero; writes ignored.
// RQ3: Reference control bits 7:6 read zero; writes ignored.
// RQ4: Reference control bit 1 reads zero; writes ignored.
// RQ5: Bit 5 picks converter ground: 0 ground pin, 1 analog ground pin.
// RQ6: Bits 4:3 pick reference: external pin, supply, digital supply, high-speed.
// RQ7: Bit 2 powers the sensor; when clear the sensor output floats.
// RQ8: Bit 0 powers the precision reference and connects it to the pin.
// RQ9: High-speed reference is powered only while the converter needs it.
// RQ10: Software uses external reference with select 00 and output enable clear.
// RQ11: With analog ground selected, tracking and conversion use the analog pin.
// RQ12: Sensor sampling always uses the internal chip ground.
// RQ13: High-speed reference selected forces chip ground during conversion.
// RQ14: Software settles the precision reference before starting the precision oscillator.
// RQ15: Offset high register holds offset bits 9:2, read only.
// RQ16: Offset is high byte concatenated with low bits 7:6; both ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "refsel_defs.vh"

module adc_reference_select_control #(
   parameter OFFSET_WIDTH = 10
) (
   // Clock and reset.
   input wire clk_sys,
   input wire rst_n,
   // Special-function register bus.
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire sfr_rd,
   input wire [7:0] sfr_wdata,
   output reg [7:0] sfr_rdata,
   // Factory offset, a fixed trim value outside this clock domain.
   input wire [OFFSET_WIDTH-1:0] factory_sensor_offset,
   // Converter phase, from logic on the same clock.
   input wire conv_tracking,
   input wire conv_converting,
   input wire conv_sampling_sensor,
   // Analog controls.
   output reg [1:0] voltage_ref_select,
   output reg analog_ground_select,
   output reg ground_mux_sel,
   output reg sensor_power_on,
   output reg precision_ref_output_enable,
   output reg high_speed_ref_power
);

   reg [7:0] reference_control;
   reg [OFFSET_WIDTH-1:0] offset_meta;
   reg [OFFSET_WIDTH-1:0] offset_sync;
   reg [7:0] next_rdata;
   reg next_ground;
   wire [1:0] sel_field;
   wire adc_busy;

   assign sel_field = reference_control[`POS_VREF_SEL_HI:`POS_VREF_SEL_LO];
   assign adc_busy = conv_tracking | conv_converting;

   // Reserved bits are masked at write time so they can never hold a one.
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reference_control <= `RESET_REFERENCE_CONTROL;
      end else if (sfr_wr && sfr_addr == `ADDR_REFERENCE_CONTROL) begin
         reference_control <= sfr_wdata & `MASK_REFERENCE_CONTROL; // RQ3
      end
   end

   // The trim pins are treated as asynchronous and pass two flops.
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         offset_meta <= {OFFSET_WIDTH{1'b0}};
         offset_sync <= {OFFSET_WIDTH{1'b0}};
      end else begin
         offset_meta <= factory_sensor_offset;
         offset_sync <= offset_meta;
      end
   end

   // Read mux; offset registers have no write path at all.
   always @* begin
      next_rdata = 8'h00;
      if (sfr_rd) begin
         case (sfr_addr)
            `ADDR_TEMP_OFFSET_LOW:
               next_rdata = {offset_sync[1:0], 6'h00}; // RQ1 RQ2 RQ16
            `ADDR_TEMP_OFFSET_HIGH:
               next_rdata = offset_sync[OFFSET_WIDTH-1:2]; // RQ15 RQ16
            `ADDR_REFERENCE_CONTROL:
               next_rdata = reference_control & `MASK_REFERENCE_CONTROL; // RQ3 RQ4
            default:
               next_rdata = 8'h00;
         endcase
      end
   end

   // Ground mux: sensor sampling and high-speed conversion override the select bit.
   always @* begin
      next_ground = `GND_CHIP;
      if (conv_tracking && conv_sampling_sensor) begin
         next_ground = `GND_CHIP; // RQ12
      end else if (conv_converting && sel_field == `VREF_HIGH_SPEED) begin
         next_ground = `GND_CHIP; // RQ13
      end else if (reference_control[`POS_GND_SEL]) begin
         next_ground = `GND_ANALOG_PIN; // RQ5 RQ11
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
         voltage_ref_select <= `VREF_HIGH_SPEED;
         analog_ground_select <= 1'b0;
         ground_mux_sel <= `GND_CHIP;
         sensor_power_on <= 1'b0;
         precision_ref_output_enable <= 1'b0;
         high_speed_ref_power <= 1'b0;
      end else begin
         sfr_rdata <= next_rdata;
         voltage_ref_select <= sel_field; // RQ6 RQ10
         analog_ground_select <= reference_control[`POS_GND_SEL]; // RQ5
         ground_mux_sel <= next_ground;
         sensor_power_on <= reference_control[`POS_SENSOR_ON]; // RQ7
         precision_ref_output_enable <= reference_control[`POS_PREC_OE]; // RQ8 RQ14
         // Kept in low power outside tracking and conversion to save current.
         high_speed_ref_power <= (sel_field == `VREF_HIGH_SPEED) && adc_busy; // RQ9
      end
   end

endmodule // adc_reference_select_control
`default_nettype wire

// [tb/refsel_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module refsel_chk (
   input wire clk_sys, rst_n, sfr_rd, sfr_wr, conv_tracking, conv_converting,
   input wire conv_sampling_sensor, analog_ground_select, ground_mux_sel,
   input wire sensor_power_on, precision_ref_output_enable, high_speed_ref_power,
   input wire [7:0] sfr_addr, sfr_wdata, sfr_rdata,
   input wire [9:0] factory_sensor_offset,
   input wire [1:0] voltage_ref_select
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence rd_of(a); sfr_rd && sfr_addr == a; endsequence
   sequence hs_sel; voltage_ref_select == 2'h3; endsequence
   rd_low_a: assert property (rd_of(8'h85) |=> sfr_rdata == {factory_sensor_offset[1:0], 6'h00})
      else $error("offset low read");
   rd_high_a: assert property (rd_of(8'h86) |=> sfr_rdata == factory_sensor_offset[9:2])
      else $error("offset high read");
   ctl_rsvd_a: assert property (rd_of(8'hd1) |=> sfr_rdata[7:6] == 2'h0 && !sfr_rdata[1])
      else $error("reserved bits");
   // Outputs lag the register by one cycle, so they show the write two edges on.
   wr_out_a: assert property (sfr_wr && sfr_addr == 8'hd1 |=> ##1 {2'h0, analog_ground_select,
      voltage_ref_select, sensor_power_on, 1'b0, precision_ref_output_enable}
      == ($past(sfr_wdata, 2) & 8'h3d)) else $error("control outputs");
   gnd_sensor_a: assert property (conv_tracking && conv_sampling_sensor |=> !ground_mux_sel)
      else $error("sensor ground");
   gnd_hs_a: assert property (conv_converting ##1 hs_sel |-> !ground_mux_sel)
      else $error("hs ground");
   gnd_pin_a: assert property (!(conv_tracking && conv_sampling_sensor) ##1 voltage_ref_select
      != 2'h3 |-> ground_mux_sel == analog_ground_select) else $error("ground pin");
   hs_on_a: assert property ((conv_tracking || conv_converting) ##1 hs_sel |-> high_speed_ref_power)
      else $error("hs power");
endmodule // refsel_chk
bind adc_reference_select_control refsel_chk chk (.*);
`default_nettype wire

// [tb/conv_model.sv]
`timescale 1ns/1ps
`default_nettype none
module conv_model (
   input wire clk_sys, go, sens,
   output logic conv_tracking, conv_converting, conv_sampling_sensor
);
   int n = 0;
   always @(posedge clk_sys) n <= n ? (n + 1) % 7 : int'(go);
   assign conv_tracking = n inside {[1:3]};
   assign conv_converting = n > 3;
   assign conv_sampling_sensor = sens;
endmodule // conv_model
`default_nettype wire

// [tb/tb_adc_reference_select_control.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_adc_reference_select_control;
   logic clk_sys = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, go = 0, sens = 0;
   logic [7:0] sfr_addr = 0, sfr_wdata = 0, d, at[4] = '{8'hd1, 8'h85, 8'h86, 8'h40};
   logic [9:0] off = 0;
   logic [31:0] s = 32'h572018f3;
   wire [7:0] sfr_rdata;
   wire [1:0] vrs;
   wire ags, gms, spo, poe, hsp, trk, cvt, smp;
   int n_fail = 0, samples_checked = 0, cyc = 0, ctl = 24;
   logic exp_g = 0, exp_h = 0;
   always #2.5 clk_sys = ~clk_sys;
   adc_reference_select_control DUT (.clk_sys, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd,
      .sfr_wdata, .sfr_rdata, .factory_sensor_offset(off), .conv_tracking(trk),
      .conv_converting(cvt), .conv_sampling_sensor(smp), .voltage_ref_select(vrs),
      .analog_ground_select(ags), .ground_mux_sel(gms), .sensor_power_on(spo),
      .precision_ref_output_enable(poe), .high_speed_ref_power(hsp));
   conv_model cm (.clk_sys, .go, .sens, .conv_tracking(trk), .conv_converting(cvt),
      .conv_sampling_sensor(smp));
   function automatic logic [31:0] rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(input logic [7:0] got, input int exp);
      samples_checked++;
      if (got !== 8'(exp)) begin
         n_fail++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic [7:0] a, input logic [7:0] v, input logic w);
      @(posedge clk_sys);
      sfr_addr <= a;
      sfr_wdata <= v;
      sfr_wr <= w;
      sfr_rd <= !w;
      go <= s[9];
      sens <= s[8];
      @(posedge clk_sys);
      sfr_wr <= 0;
      sfr_rd <= 0;
      if (w && a == 8'hd1) ctl <= v & 8'h3d;
      #1;
   endtask
   task automatic wctl(input logic [7:0] a, input logic [7:0] v);
      acc(a, v, 1);
      @(posedge clk_sys);
      #1;
      chk({2'h0, ags, vrs, spo, 1'b0, poe}, ctl);
   endtask
   task automatic chk_gnd(input logic [1:0] got, input logic [1:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: ground/power got %b want %b", $time, got, exp);
      end
   endtask
   // Ground and high-speed power model; it sees the register as it stood before each edge.
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         exp_g <= 0;
         exp_h <= 0;
      end else begin
         exp_g <= (trk && smp) ? 1'b0 : (cvt && ctl[4:3] == 3) ? 1'b0 : ctl[5];
         exp_h <= (ctl[4:3] == 3) && (trk || cvt);
      end
   end
   always @(negedge clk_sys) begin
      chk_gnd({gms, hsp}, {exp_g, exp_h});
   end
   task automatic end_of_test();
      $display("checked %0d, failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk_sys) if (++cyc == 3000) begin
      n_fail++;
      end_of_test();
   end
   initial begin
      off = 10'(rnd());
      repeat (4) @(posedge clk_sys);
      rst_n <= 1;
      acc(8'hd1, 0, 0);
      chk(sfr_rdata, ctl);
      // Writes go to control, both offset bytes and an unmapped place in turn.
      for (int i = 0; i < 16; i++) begin
         d = 8'(rnd());
         d[4:3] = i[1:0];
         wctl(at[i / 4], d);
         foreach (at[j]) begin
            acc(at[j], 0, 0);
            chk(sfr_rdata, j == 0 ? ctl : j == 1 ? {off[1:0], 6'h00} : j == 2 ? off[9:2] : 0);
         end
      end
      wctl(8'hd1, 8'h00);
      wctl(8'hd1, 8'h01);
      end_of_test();
   end
endmodule // tb_adc_reference_select_control
`default_nettype wire
